//--- rtl/plc_state_pkg.sv
`default_nettype none
package plc_state_pkg;
  // Selector positions
  localparam logic [1:0] SEL_HALT = 2'h0;
  localparam logic [1:0] SEL_RUN = 2'h1;
  localparam logic [1:0] SEL_RUN_MRESET = 2'h2;
  // Start conditions
  localparam logic [1:0] START_HALT = 2'h0;
  localparam logic [1:0] START_WARM = 2'h1;
  localparam logic [1:0] START_COLD = 2'h2;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int DIP_BRIDGE_MS = 10;
  localparam int HOLDUP_MS = 5;
  localparam int DIP_BRIDGE_CYC = DIP_BRIDGE_MS * 1000 * CLK_MHZ;
  localparam int HOLDUP_CYC = HOLDUP_MS * 1000 * CLK_MHZ;
  localparam int FLASH_MS = 1;
  localparam int FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
  // Reset values
  localparam logic [15:0] DIAG_WORD_RESET = 16'h0000;
  typedef enum logic [2:0] {
    ST_SELFTEST, ST_FLASH, ST_SYNC, ST_READY, ST_RUN, ST_NOT_READY, ST_SAVE, ST_BLINK
  } op_state_t;
endpackage
`default_nettype wire

//--- rtl/plc_operating_state_control.sv
`timescale 1ns/1ps
`default_nettype none
module plc_operating_state_control #(
  parameter int DIP_CYC = plc_state_pkg::DIP_BRIDGE_CYC,
  parameter int HOLD_CYC = plc_state_pkg::HOLDUP_CYC,
  parameter int FLASH_LEN = plc_state_pkg::FLASH_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Operator pins
  input wire logic [1:0] i_selector,
  input wire logic i_reset_button,
  input wire logic i_power_low,
  input wire logic i_module_tab_out,
  input wire logic i_master_halt,
  // Configuration
  input wire logic i_slave_mode,
  input wire logic i_remote_ctrl,
  input wire logic [1:0] i_start_cond,
  // Self-test and program status
  input wire logic i_test_done,
  input wire logic i_test_fail,
  input wire logic i_prog_present,
  input wire logic i_hw_fault,
  input wire logic i_prog_fault,
  input wire logic i_cycle_end,
  input wire logic i_prog_equal,
  input wire logic i_module_defect,
  input wire logic i_ram_valid,
  input wire logic i_copy_done,
  input wire logic i_save_done,
  input wire logic i_module_boot,
  // PC commands, single-cycle pulses
  input wire logic i_pc_ready_cmd,
  input wire logic i_pc_run_cmd,
  input wire logic i_pc_reset_cmd,
  input wire logic i_pc_transfer,
  input wire logic [15:0] i_diag_set,
  // Status outputs
  output logic o_ready,
  output logic o_run,
  output logic o_not_ready,
  output logic o_led_ready,
  output logic o_led_run,
  output logic o_led_not_ready,
  output logic o_outputs_enable,
  output logic o_pc_link_enable,
  output logic o_cold_start,
  output logic o_warm_start,
  output logic o_copy_backup,
  output logic o_write_module,
  output logic o_save_restart,
  output logic o_self_test,
  output logic [15:0] o_diag_status_word
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [10:0] sync1;
  logic [10:0] sync2;
  logic [10:0] pin_raw;
  assign pin_raw = {i_selector, i_reset_button, i_power_low, i_module_tab_out,
                    i_master_halt, i_slave_mode, i_remote_ctrl, i_start_cond, 1'b0};
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end
  wire [1:0] sel = sync2[10:9];
  wire btn = sync2[8];
  wire pwr_low = sync2[7];
  wire tab_out = sync2[6];
  wire mst_halt = sync2[5];
  wire slave = sync2[4];
  wire remote = sync2[3];
  wire [1:0] start_cond = sync2[2:1];

  logic btn_d;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) btn_d <= 1'b0;
    else btn_d <= btn;
  end
  wire btn_press = btn & ~btn_d;

  ////////////////////////////////////////////////////////////////////////
  // State and counters
  plc_state_pkg::op_state_t state, next_state;
  logic [31:0] dip_cnt;
  logic [31:0] tmr;
  logic [23:0] blink_cnt;
  logic pending_halt;
  logic pwr_cycle;
  logic [15:0] diag_word;
  logic via_ready;
  logic need_cold;

  wire dip_long = pwr_low && (dip_cnt >= 32'(DIP_CYC));
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) dip_cnt <= '0;
    else if (!pwr_low) dip_cnt <= '0;
    else if (!dip_long) dip_cnt <= dip_cnt + 32'h0000_0001;
  end

  wire is_halt = (sel == plc_state_pkg::SEL_HALT);
  wire is_mres = (sel == plc_state_pkg::SEL_RUN_MRESET);
  wire fault = i_hw_fault | i_prog_fault | ~i_prog_present;
  wire remote_halt = slave & remote & mst_halt;
  wire ready_req = i_pc_ready_cmd | remote_halt | tab_out | (btn_press & is_halt);
  wire run_req = i_pc_run_cmd | (btn_press & ~is_halt);
  wire load_evt = i_pc_transfer | i_module_boot;
  wire load_halt = load_evt && (start_cond == plc_state_pkg::START_HALT);
  wire start_evt = (state == plc_state_pkg::ST_SYNC);

  always_comb begin
    next_state = state;
    case (state)
      plc_state_pkg::ST_SELFTEST: begin
        if (i_test_done) next_state = i_test_fail ? plc_state_pkg::ST_BLINK
                                                  : plc_state_pkg::ST_FLASH;
      end
      plc_state_pkg::ST_FLASH: begin
        if (tmr >= 32'(FLASH_LEN)) next_state = plc_state_pkg::ST_SYNC;
      end
      plc_state_pkg::ST_SYNC: begin
        if (i_prog_equal || i_copy_done || i_module_defect) begin
          if (fault) next_state = plc_state_pkg::ST_NOT_READY;
          else if (is_halt || pwr_cycle && !i_prog_present)
            next_state = pwr_cycle && via_ready ? plc_state_pkg::ST_NOT_READY
                                                : plc_state_pkg::ST_READY;
          else next_state = plc_state_pkg::ST_RUN;
        end
      end
      plc_state_pkg::ST_READY: begin
        if (fault) next_state = plc_state_pkg::ST_NOT_READY;
        else if (load_halt) next_state = plc_state_pkg::ST_NOT_READY;
        else if (run_req && !ready_req) next_state = plc_state_pkg::ST_SYNC;
      end
      plc_state_pkg::ST_RUN: begin
        if (fault) next_state = plc_state_pkg::ST_NOT_READY;
        else if (ready_req) next_state = plc_state_pkg::ST_READY;
      end
      plc_state_pkg::ST_NOT_READY: begin
        if (fault) next_state = plc_state_pkg::ST_NOT_READY;
        else if (ready_req) next_state = plc_state_pkg::ST_READY;
        else if (btn_press || i_pc_reset_cmd || i_pc_run_cmd)
          next_state = plc_state_pkg::ST_SYNC;
      end
      plc_state_pkg::ST_SAVE: begin
        if (!pwr_low && i_save_done) next_state = plc_state_pkg::ST_SELFTEST;
      end
      plc_state_pkg::ST_BLINK: next_state = plc_state_pkg::ST_BLINK;
      default: next_state = plc_state_pkg::ST_SELFTEST;
    endcase
    // long dip saves restart data; cycle finish
    if (dip_long && state != plc_state_pkg::ST_SAVE && state != plc_state_pkg::ST_BLINK &&
        (state != plc_state_pkg::ST_RUN || i_cycle_end))
      next_state = plc_state_pkg::ST_SAVE;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= plc_state_pkg::ST_SELFTEST;
      tmr <= '0;
      pwr_cycle <= 1'b1;
      via_ready <= 1'b0;
      need_cold <= 1'b0;
      blink_cnt <= '0;
    end else begin
      state <= next_state;
      blink_cnt <= blink_cnt + 24'h00_0001;
      tmr <= (next_state != state) ? 32'h0000_0000 : tmr + 32'h0000_0001;
      if (next_state == plc_state_pkg::ST_SAVE) begin
        pwr_cycle <= 1'b1;
        via_ready <= (state == plc_state_pkg::ST_NOT_READY) && is_halt;
      end else if (state == plc_state_pkg::ST_SYNC && next_state != state) begin
        pwr_cycle <= 1'b0;
      end
      if (load_evt) need_cold <= 1'b1;
      else if (o_cold_start) need_cold <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) diag_word <= plc_state_pkg::DIAG_WORD_RESET;
    else diag_word <= (btn_press ? 16'h0000 : diag_word) | i_diag_set;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  wire blink = blink_cnt[23];
  wire leaving_sync = start_evt && next_state == plc_state_pkg::ST_RUN;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cold_start <= 1'b0;
      o_warm_start <= 1'b0;
      o_copy_backup <= 1'b0;
      o_write_module <= 1'b0;
    end else begin
      o_cold_start <= leaving_sync && (is_mres || need_cold ||
                      start_cond == plc_state_pkg::START_COLD);
      o_warm_start <= leaving_sync && !is_mres && !need_cold &&
                      start_cond != plc_state_pkg::START_COLD;
      o_copy_backup <= start_evt && !i_prog_equal && !i_module_defect && !i_copy_done;
      o_write_module <= i_pc_transfer || (start_evt && i_module_defect && i_ram_valid);
    end
  end

  assign o_ready = (state == plc_state_pkg::ST_READY);
  assign o_run = (state == plc_state_pkg::ST_RUN);
  assign o_not_ready = (state == plc_state_pkg::ST_NOT_READY);
  assign o_led_ready = o_ready | (state == plc_state_pkg::ST_FLASH) |
                       ((state == plc_state_pkg::ST_BLINK) & blink);
  assign o_led_run = o_run | (state == plc_state_pkg::ST_FLASH) |
                     ((state == plc_state_pkg::ST_BLINK) & blink);
  assign o_led_not_ready = o_not_ready | (state == plc_state_pkg::ST_FLASH) |
                           ((state == plc_state_pkg::ST_BLINK) & blink);
  assign o_outputs_enable = o_run;
  assign o_pc_link_enable = o_ready | o_run | o_not_ready;
  assign o_save_restart = (state == plc_state_pkg::ST_SAVE);
  assign o_self_test = (state == plc_state_pkg::ST_SELFTEST);
  assign o_diag_status_word = diag_word;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  // outputs held off
  ready_outs_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_ready |-> !o_outputs_enable) else $error("outputs enabled in ready");
  fault_prio_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_run && fault && !dip_long) |=> o_not_ready) else $error("fault not honoured");
  ready_fault_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_ready && i_hw_fault && !dip_long) |=> o_not_ready) else $error("fault ignored in ready");
  blink_fail_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_self_test && i_test_done && i_test_fail) |=> state == plc_state_pkg::ST_BLINK)
    else $error("failed test not blinking");
  tab_ready_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_run && tab_out && !fault && !dip_long) |=> o_ready) else $error("tab ignored");
  pc_link_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_ready || o_run || o_not_ready) |-> o_pc_link_enable) else $error("pc link off");
  short_dip_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!dip_long && !o_save_restart) |=> !o_save_restart) else $error("short dip saved");
  transfer_wr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_pc_transfer |=> o_write_module) else $error("module not updated");
  diag_ack_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (btn_press && i_diag_set == 16'h0000) |=> o_diag_status_word == 16'h0000)
    else $error("status word not acknowledged");

endmodule
`default_nettype wire

//--- tb/plc_operator_model.sv
`timescale 1ns/1ps
`default_nettype none
module plc_operator_model (
  // Clock
  input wire logic i_ref_clk,
  // Operator panel
  output logic [1:0] o_selector,
  output logic o_reset_button,
  // PC commands
  output logic o_pc_ready_cmd,
  output logic o_pc_run_cmd,
  output logic o_pc_reset_cmd,
  output logic o_pc_transfer
);
  logic [3:0] cmd = 4'h0;
  initial o_selector = plc_state_pkg::SEL_HALT;
  initial o_reset_button = 1'b0;
  assign {o_pc_transfer, o_pc_reset_cmd, o_pc_run_cmd, o_pc_ready_cmd} = cmd;
  //////////////////////////////////////////////////////////////////////////////
  // Selector change, held as a level
  task automatic sel(input logic [1:0] v);
    @(negedge i_ref_clk);
    o_selector = v;
    repeat (4) @(negedge i_ref_clk);
  endtask
  task automatic press();
    @(negedge i_ref_clk);
    o_reset_button = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    o_reset_button = 1'b0;
    repeat (6) @(negedge i_ref_clk);
  endtask
  // One-cycle command pulse
  task automatic pc(input int k);
    @(negedge i_ref_clk);
    cmd[k] = 1'b1;
    @(negedge i_ref_clk);
    cmd = 4'h0;
  endtask
endmodule
`default_nettype wire

//--- tb/plc_operating_state_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module plc_operating_state_control_tb_top;
  logic i_ref_clk = 0, i_rst_n = 0;
  logic [1:0] i_selector, i_start_cond = plc_state_pkg::START_WARM;
  logic i_reset_button, i_power_low = 0, i_module_tab_out = 0, i_master_halt = 0;
  logic i_slave_mode = 0, i_remote_ctrl = 0, i_test_done = 0, i_test_fail = 0;
  logic i_prog_present = 1, i_hw_fault = 0, i_prog_fault = 0, i_cycle_end = 0;
  logic i_prog_equal = 1, i_module_defect = 0, i_ram_valid = 1, i_copy_done = 0;
  logic i_save_done = 1, i_module_boot = 0;
  logic i_pc_ready_cmd, i_pc_run_cmd, i_pc_reset_cmd, i_pc_transfer;
  logic [15:0] i_diag_set = 16'h0000, o_diag_status_word;
  logic o_ready, o_run, o_not_ready, o_led_ready, o_led_run, o_led_not_ready;
  logic o_outputs_enable, o_pc_link_enable, o_cold_start, o_warm_start;
  logic o_copy_backup, o_write_module, o_save_restart, o_self_test;
  int mismatches = 0, checked = 0, nc = 0, nw = 0, ncp = 0, nwm = 0, nsv = 0;
  wire [2:0] st = {o_not_ready, o_run, o_ready};
  always #2 i_ref_clk = ~i_ref_clk;
  //////////////////////////////////////////////////////////////////////////////
  plc_operating_state_control #(.DIP_CYC(8), .HOLD_CYC(8), .FLASH_LEN(8))
    plc_operating_state_control_i (
    .i_ref_clk, .i_rst_n, .i_selector, .i_reset_button, .i_power_low, .i_module_tab_out,
    .i_master_halt, .i_slave_mode, .i_remote_ctrl, .i_start_cond, .i_test_done,
    .i_test_fail, .i_prog_present, .i_hw_fault, .i_prog_fault, .i_cycle_end,
    .i_prog_equal, .i_module_defect, .i_ram_valid, .i_copy_done, .i_save_done,
    .i_module_boot, .i_pc_ready_cmd, .i_pc_run_cmd, .i_pc_reset_cmd, .i_pc_transfer,
    .i_diag_set, .o_ready, .o_run, .o_not_ready, .o_led_ready, .o_led_run,
    .o_led_not_ready, .o_outputs_enable, .o_pc_link_enable, .o_cold_start,
    .o_warm_start, .o_copy_backup, .o_write_module, .o_save_restart, .o_self_test,
    .o_diag_status_word);
  plc_operator_model plc_operator_model_i (
    .i_ref_clk(i_ref_clk), .o_selector(i_selector), .o_reset_button(i_reset_button),
    .o_pc_ready_cmd(i_pc_ready_cmd), .o_pc_run_cmd(i_pc_run_cmd),
    .o_pc_reset_cmd(i_pc_reset_cmd), .o_pc_transfer(i_pc_transfer));
  //////////////////////////////////////////////////////////////////////////////
  // Program cycle ends and copy answers
  always @(negedge i_ref_clk) begin
    i_cycle_end <= ~i_cycle_end;
    i_copy_done <= o_copy_backup;
  end
  // Pulse counters
  always @(posedge i_ref_clk) begin
    nc <= nc + o_cold_start;
    nw <= nw + o_warm_start;
    ncp <= ncp + o_copy_backup;
    nwm <= nwm + o_write_module;
    nsv <= nsv + o_save_restart;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic go(input logic [2:0] e);
    for (int k = 0; k < 100 && st !== e; k++) @(negedge i_ref_clk);
    chk("state", 16'(e), 16'(st));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic boot(input logic fail);
    cyc(1);
    i_test_fail = fail;
    i_test_done = 1;
    cyc(1);
    i_test_done = 0;
    cyc(1);
  endtask
  task automatic clr();
    nc = 0;
    nw = 0;
    ncp = 0;
    nwm = 0;
    nsv = 0;
  endtask
  task end_of_test;
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    mismatches++;
    end_of_test;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(10);
    i_rst_n = 1;
    chk("self_test", 16'h0001, 16'(o_self_test));
    i_prog_equal = 0;
    boot(0);
    chk("leds", 16'h0007, 16'({o_led_ready, o_led_run, o_led_not_ready}));
    go(3'h1);
    chk("copy", 16'h0001, 16'(ncp != 0));
    chk("out_en", 16'h0000, 16'(o_outputs_enable));
    chk("pc_link", 16'h0001, 16'(o_pc_link_enable));
    i_prog_equal = 1;
    plc_operator_model_i.sel(plc_state_pkg::SEL_RUN);
    plc_operator_model_i.press();
    go(3'h2);
    chk("warm", 16'h0001, 16'(nw != 0));
    chk("out_en", 16'h0001, 16'(o_outputs_enable));
    i_diag_set = 16'h0005;
    cyc(1);
    i_diag_set = 16'h0000;
    cyc(2);
    chk("diag_word", 16'h0005, o_diag_status_word);
    plc_operator_model_i.press();
    chk("diag_word", 16'h0000, o_diag_status_word);
    go(3'h2);
    plc_operator_model_i.pc(0);
    go(3'h1);
    chk("pc_link", 16'h0001, 16'(o_pc_link_enable));
    clr();
    i_hw_fault = 1;
    plc_operator_model_i.pc(1);
    go(3'h4);
    chk("out_en", 16'h0000, 16'(o_outputs_enable));
    chk("starts", 16'h0000, 16'(nc + nw));
    i_hw_fault = 0;
    clr();
    plc_operator_model_i.sel(plc_state_pkg::SEL_RUN_MRESET);
    plc_operator_model_i.press();
    go(3'h2);
    chk("cold", 16'h0001, 16'(nc != 0));
    i_module_tab_out = 1;
    go(3'h1);
    i_module_tab_out = 0;
    cyc(3);
    plc_operator_model_i.pc(1);
    go(3'h2);
    i_slave_mode = 1;
    i_remote_ctrl = 1;
    i_master_halt = 1;
    go(3'h1);
    i_slave_mode = 0;
    i_remote_ctrl = 0;
    i_master_halt = 0;
    i_start_cond = plc_state_pkg::START_HALT;
    plc_operator_model_i.sel(plc_state_pkg::SEL_HALT);
    plc_operator_model_i.pc(3);
    cyc(3);
    chk("write_mod", 16'h0001, 16'(nwm != 0));
    go(3'h4);
    i_start_cond = plc_state_pkg::START_WARM;
    plc_operator_model_i.press();
    go(3'h1);
    clr();
    i_power_low = 1;
    cyc(4);
    i_power_low = 0;
    cyc(20);
    chk("short_dip", 16'h0000, 16'(nsv));
    go(3'h1);
    i_power_low = 1;
    cyc(30);
    chk("long_dip", 16'h0001, 16'(nsv != 0));
    i_power_low = 0;
    cyc(10);
    boot(0);
    go(3'h1);
    clr();
    plc_operator_model_i.sel(plc_state_pkg::SEL_RUN);
    plc_operator_model_i.pc(1);
    go(3'h2);
    cyc(2);
    chk("cold", 16'h0001, 16'(nc != 0));
    i_power_low = 1;
    cyc(30);
    i_power_low = 0;
    cyc(10);
    boot(0);
    go(3'h2);
    chk("run_dip", 16'h0001, 16'(nsv != 0));
    i_prog_fault = 1;
    go(3'h4);
    i_prog_fault = 0;
    i_module_defect = 1;
    i_prog_equal = 0;
    clr();
    plc_operator_model_i.pc(2);
    go(3'h2);
    cyc(2);
    chk("write_mod", 16'h0001, 16'(nwm != 0));
    chk("copy", 16'h0000, 16'(ncp));
    i_module_defect = 0;
    i_prog_equal = 1;
    i_rst_n = 0;
    cyc(10);
    i_rst_n = 1;
    boot(1);
    cyc(50);
    chk("fail_state", 16'h0000, 16'(st));
    end_of_test;
  end
endmodule
`default_nettype wire
